// ==== src/osd_pkg.sv ====
package osd_pkg;
  // Register byte addresses (printed offsets are indices, not all multiples of four)
  localparam logic [7:0] OSD_IDX_CH7_DIV    = 8'h2C;
  localparam logic [7:0] OSD_IDX_ROUTE_CTRL = 8'h2D;
  localparam logic [7:0] OSD_IDX_CMOS_A     = 8'h2E;
  localparam logic [7:0] OSD_IDX_SRC_CTRL   = 8'h30;
  localparam logic [9:0] OSD_ADDR_CH7_DIV    = {OSD_IDX_CH7_DIV, 2'b00};
  localparam logic [9:0] OSD_ADDR_ROUTE_CTRL = {OSD_IDX_ROUTE_CTRL, 2'b00};
  localparam logic [9:0] OSD_ADDR_CMOS_A     = {OSD_IDX_CMOS_A, 2'b00};
  localparam logic [9:0] OSD_ADDR_SRC_CTRL   = {OSD_IDX_SRC_CTRL, 2'b00};
  // Reset values
  localparam logic [7:0] OSD_RST_CH7_DIV    = 8'h05;
  localparam logic [7:0] OSD_RST_ROUTE_CTRL = 8'h0A;
  localparam logic [7:0] OSD_RST_CMOS_A     = 8'h00;
  localparam logic [7:0] OSD_RST_SRC_CTRL   = 8'h00;
  // Route control field positions
  localparam int OSD_PREDIV_LSB  = 4;
  localparam int OSD_ROUTE_B_LSB = 2;
  localparam int OSD_ROUTE_A_LSB = 0;
  // Source control field positions
  localparam int OSD_CH7_SRC_LSB  = 0;
  localparam int OSD_CMOS_SRC_BIT = 2;
  // Pre-divider ratios
  localparam logic [7:0] OSD_PREDIV_RATIO_4 = 8'h03;
  localparam logic [7:0] OSD_PREDIV_RATIO_5 = 8'h04;
  // Smallest ratio of the first CMOS divider (value, ratio minus one)
  localparam logic [7:0] OSD_CMOS_A_MIN     = 8'h05;
  // Channel source codes
  typedef enum logic [1:0] {
    OSD_SRC_SYNTH  = 2'h0,
    OSD_SRC_SYNTH2 = 2'h1,
    OSD_SRC_PRI    = 2'h2,
    OSD_SRC_SEC    = 2'h3
  } osd_src_e;
  // Status pin routes
  typedef enum logic [1:0] {
    OSD_ROUTE_DIV_A  = 2'h0,
    OSD_ROUTE_DIV_B  = 2'h1,
    OSD_ROUTE_STATUS = 2'h2,
    OSD_ROUTE_OFF    = 2'h3
  } osd_route_e;
  // Pre-divider selects
  typedef enum logic [1:0] {
    OSD_PREDIV_OFF = 2'h0,
    OSD_PREDIV_4   = 2'h1,
    OSD_PREDIV_5   = 2'h2,
    OSD_PREDIV_RSV = 2'h3
  } osd_prediv_e;
endpackage : osd_pkg

// ==== src/osd_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// Divide-by-(ratio+1) clock enable counter with a square-ish output
module osd_div (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       en_i,     // Input tick qualifies counting
  input  wire logic       run_i,    // Low holds the divider cleared
  input  wire logic [7:0] ratio_i,  // Divide ratio minus one
  // Outputs
  output logic            tick_o,   // One pulse per output period
  output logic            clk_o     // Divided level
);
  logic [7:0] cnt_reg;  // Position in the period

  // Count input ticks and wrap at ratio
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= 8'h00;
    end else if (en_i) begin
      cnt_reg <= (cnt_reg >= ratio_i) ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  // Pulse on wrap
  assign tick_o = run_i && en_i && (cnt_reg >= ratio_i);

  // Level high during the first half of the period
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      clk_o <= 1'b0;
    end else if (en_i) begin
      if (ratio_i == 8'h00) begin
        clk_o <= ~clk_o;
      end else begin
        clk_o <= (cnt_reg >= ratio_i) || (cnt_reg < (ratio_i >> 1));
      end
    end
  end
endmodule : osd_div
`default_nettype wire

// ==== src/osd_top.sv ====
// Notes on behaviour
// - Channel 7 ratio is value plus one, reset 0x05
// - Channel 7 divides only for synthesizer sources
// - Status pins may carry either CMOS divider clock
// - Pre-divider fed by either synthesizer
// - Pre-divider: off, by 4, by 5, reserved
// - Pin B route: div A, div B, status, off
// - Pin A route uses same four codes
// - First CMOS divider 8-bit, from pre-divider, reset 0
// - Zero disables, 1-5 give 6, else value+1
`timescale 1ns/1ps
`default_nettype none
module osd_top
  import osd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Clock sources as single-cycle ticks of the system clock
  input  wire logic        synth_tick_i,
  input  wire logic        synth2_tick_i,
  input  wire logic        ref_pri_i,
  input  wire logic        ref_sec_i,
  // Status and second CMOS divider inputs
  input  wire logic        status_a_i,
  input  wire logic        status_b_i,
  input  wire logic        cmos_b_clk_i,
  // Outputs
  output logic             ch7_clk_o,
  output logic             cmos_a_clk_o,
  output logic             status_pin_a_o,
  output logic             status_pin_a_oe_n_o,
  output logic             status_pin_b_o,
  output logic             status_pin_b_oe_n_o
);
  // Registers
  logic [7:0] ch7_div_reg;     // Channel 7 ratio minus one
  logic [7:0] route_reg;       // Reserved, pre-divider, pin routes
  logic [7:0] cmos_a_reg;      // First CMOS divider value
  logic [7:0] src_reg;         // Channel and CMOS source selects
  logic       ack_reg;         // Bus acknowledge

  // Decoded fields
  osd_src_e    ch7_src;
  osd_prediv_e prediv_sel;
  osd_route_e  route_a;
  osd_route_e  route_b;
  logic        cmos_src_sel;

  // Bus access
  logic       bus_req;
  logic       wr_en;
  logic [7:0] rd_data;

  // Datapath
  logic       ch7_raw;
  logic       ch7_div_clk;
  logic       ch7_synth_src;
  logic       pre_in_tick;
  logic       pre_run;
  logic [7:0] pre_ratio;
  logic       pre_tick;
  logic       cmos_a_run;
  logic [7:0] cmos_a_ratio;
  logic       cmos_a_div_clk;
  logic       pin_a_next;
  logic       pin_b_next;
  logic       oe_a_next;
  logic       oe_b_next;

  assign ch7_src      = osd_src_e'(src_reg[OSD_CH7_SRC_LSB +: 2]);
  assign cmos_src_sel = src_reg[OSD_CMOS_SRC_BIT];
  assign prediv_sel   = osd_prediv_e'(route_reg[OSD_PREDIV_LSB +: 2]);
  assign route_b      = osd_route_e'(route_reg[OSD_ROUTE_B_LSB +: 2]);
  assign route_a      = osd_route_e'(route_reg[OSD_ROUTE_A_LSB +: 2]);

  // Request qualification, write only while ack is low
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_en   = bus_req && wb_we_i && wb_sel_i[0];

  // Acknowledge one cycle after the request, dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end
  assign wb_ack_o = ack_reg;

  // Channel 7 ratio register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch7_div_reg <= OSD_RST_CH7_DIV;
    end else if (wr_en && wb_adr_i == OSD_ADDR_CH7_DIV) begin
      ch7_div_reg <= wb_dat_i[7:0];
    end
  end

  // Route control register, reserved bits kept as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_reg <= OSD_RST_ROUTE_CTRL;
    end else if (wr_en && wb_adr_i == OSD_ADDR_ROUTE_CTRL) begin
      route_reg <= wb_dat_i[7:0];
    end
  end

  // First CMOS divider value register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmos_a_reg <= OSD_RST_CMOS_A;
    end else if (wr_en && wb_adr_i == OSD_ADDR_CMOS_A) begin
      cmos_a_reg <= wb_dat_i[7:0];
    end
  end

  // Source select register, three bits implemented
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_reg <= OSD_RST_SRC_CTRL;
    end else if (wr_en && wb_adr_i == OSD_ADDR_SRC_CTRL) begin
      src_reg <= {5'h00, wb_dat_i[2:0]};
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    unique case (wb_adr_i)
      OSD_ADDR_CH7_DIV:    rd_data = ch7_div_reg;
      OSD_ADDR_ROUTE_CTRL: rd_data = route_reg;
      OSD_ADDR_CMOS_A:     rd_data = cmos_a_reg;
      OSD_ADDR_SRC_CTRL:   rd_data = src_reg;
      default:             rd_data = 8'h00;
    endcase
  end

  // Read data captured with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      wb_dat_o <= {24'h00_0000, rd_data};
    end
  end

  // Channel 7 source mux; divider used only for synthesizer sources
  always_comb begin
    ch7_synth_src = 1'b0;
    ch7_raw       = 1'b0;
    unique case (ch7_src)
      OSD_SRC_SYNTH: begin
        ch7_raw       = synth_tick_i;
        ch7_synth_src = 1'b1;
      end
      OSD_SRC_SYNTH2: begin
        ch7_raw       = synth2_tick_i;
        ch7_synth_src = 1'b1;
      end
      OSD_SRC_PRI:    ch7_raw = ref_pri_i;
      OSD_SRC_SEC:    ch7_raw = ref_sec_i;
    endcase
  end

  // Channel 7 output divider, ratio value plus one
  osd_div u_ch7_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (ch7_raw),
    .run_i   (ch7_synth_src),
    .ratio_i (ch7_div_reg),
    .tick_o  (),
    .clk_o   (ch7_div_clk)
  );

  // Channel 7 output: divided or bypassed reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch7_clk_o <= 1'b0;
    end else begin
      ch7_clk_o <= ch7_synth_src ? ch7_div_clk : ch7_raw;
    end
  end

  // Pre-divider input from either synthesizer
  assign pre_in_tick = cmos_src_sel ? synth2_tick_i : synth_tick_i;

  // Pre-divider ratio decode, reserved code treated as disabled
  always_comb begin
    pre_run   = 1'b0;
    pre_ratio = 8'h00;
    unique case (prediv_sel)
      OSD_PREDIV_OFF: pre_run = 1'b0;
      OSD_PREDIV_4: begin
        pre_run   = 1'b1;
        pre_ratio = OSD_PREDIV_RATIO_4;
      end
      OSD_PREDIV_5: begin
        pre_run   = 1'b1;
        pre_ratio = OSD_PREDIV_RATIO_5;
      end
      OSD_PREDIV_RSV: pre_run = 1'b0;
    endcase
  end

  // Pre-divider
  osd_div u_prediv (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (pre_in_tick),
    .run_i   (pre_run),
    .ratio_i (pre_ratio),
    .tick_o  (pre_tick),
    .clk_o   ()
  );

  // First CMOS divider decode: zero off, small values clamp to six
  assign cmos_a_run   = (cmos_a_reg != 8'h00);
  assign cmos_a_ratio = (cmos_a_reg < OSD_CMOS_A_MIN) ? OSD_CMOS_A_MIN : cmos_a_reg;

  // First CMOS divider, fed by the pre-divider output
  osd_div u_cmos_a (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (pre_tick),
    .run_i   (cmos_a_run && pre_run),
    .ratio_i (cmos_a_ratio),
    .tick_o  (),
    .clk_o   (cmos_a_div_clk)
  );
  assign cmos_a_clk_o = cmos_a_div_clk;

  // Pin route decode for both status pins
  always_comb begin
    pin_a_next = 1'b0;
    oe_a_next  = 1'b0;
    unique case (route_a)
      OSD_ROUTE_DIV_A:  pin_a_next = cmos_a_div_clk;
      OSD_ROUTE_DIV_B:  pin_a_next = cmos_b_clk_i;
      OSD_ROUTE_STATUS: pin_a_next = status_a_i;
      OSD_ROUTE_OFF:    oe_a_next  = 1'b1;
    endcase
    pin_b_next = 1'b0;
    oe_b_next  = 1'b0;
    unique case (route_b)
      OSD_ROUTE_DIV_A:  pin_b_next = cmos_a_div_clk;
      OSD_ROUTE_DIV_B:  pin_b_next = cmos_b_clk_i;
      OSD_ROUTE_STATUS: pin_b_next = status_b_i;
      OSD_ROUTE_OFF:    oe_b_next  = 1'b1;
    endcase
  end

  // Registered pin drivers, enables active low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_pin_a_o      <= 1'b0;
      status_pin_a_oe_n_o <= 1'b0;
      status_pin_b_o      <= 1'b0;
      status_pin_b_oe_n_o <= 1'b0;
    end else begin
      status_pin_a_o      <= pin_a_next;
      status_pin_a_oe_n_o <= oe_a_next;
      status_pin_b_o      <= pin_b_next;
      status_pin_b_oe_n_o <= oe_b_next;
    end
  end
endmodule : osd_top
`default_nettype wire

// ==== verification/osd_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus handshake and status pin routing checks
module osd_top_properties
  import osd_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus requests
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Pin sources and pins
  input wire logic        status_a_i,
  input wire logic        status_b_i,
  input wire logic        cmos_b_clk_i,
  input wire logic        cmos_a_clk_o,
  input wire logic        status_pin_a_o,
  input wire logic        status_pin_a_oe_n_o,
  input wire logic        status_pin_b_o,
  input wire logic        status_pin_b_oe_n_o
);
  logic [3:0] rt_reg;  // Shadow of both route fields
  logic [3:0] rt1_reg; // Shadow one cycle old
  logic [3:0] rt2_reg; // Shadow two cycles old
  // Route stable long enough for the pin pipeline to follow it
  wire logic sa = (rt_reg[1:0] == rt1_reg[1:0]) && (rt1_reg[1:0] == rt2_reg[1:0]);
  wire logic sb = (rt_reg[3:2] == rt1_reg[3:2]) && (rt1_reg[3:2] == rt2_reg[3:2]);
  // Track route writes; old copies start unlike so reset exit is skipped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt_reg  <= OSD_RST_ROUTE_CTRL[3:0];
      rt1_reg <= 4'h0;
      rt2_reg <= 4'h0;
    end else begin
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i == OSD_ADDR_ROUTE_CTRL) begin
        rt_reg <= wb_dat_i[3:0];
      end
      rt1_reg <= rt_reg;
      rt2_reg <= rt1_reg;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_pin_a_off: assert property (sa && rt_reg[1:0] == 2'h3 |-> status_pin_a_oe_n_o && !status_pin_a_o)
    else $error("pin a not disabled");
  a_pin_b_off: assert property (sb && rt_reg[3:2] == 2'h3 |-> status_pin_b_oe_n_o && !status_pin_b_o)
    else $error("pin b not disabled");
  a_pin_a_status: assert property (sa && rt_reg[1:0] == 2'h2 |-> !status_pin_a_oe_n_o && status_pin_a_o == $past(status_a_i))
    else $error("pin a not showing status");
  a_pin_b_status: assert property (sb && rt_reg[3:2] == 2'h2 |-> !status_pin_b_oe_n_o && status_pin_b_o == $past(status_b_i))
    else $error("pin b not showing status");
  a_pin_a_diva: assert property (sa && rt_reg[1:0] == 2'h0 |-> !status_pin_a_oe_n_o && status_pin_a_o == $past(cmos_a_clk_o))
    else $error("pin a not carrying divider a");
  a_pin_a_divb: assert property (sa && rt_reg[1:0] == 2'h1 |-> !status_pin_a_oe_n_o && status_pin_a_o == $past(cmos_b_clk_i))
    else $error("pin a not carrying divider b");
  a_pin_b_diva: assert property (sb && rt_reg[3:2] == 2'h0 |-> !status_pin_b_oe_n_o && status_pin_b_o == $past(cmos_a_clk_o))
    else $error("pin b not carrying divider a");
  a_pin_b_divb: assert property (sb && rt_reg[3:2] == 2'h1 |-> !status_pin_b_oe_n_o && status_pin_b_o == $past(cmos_b_clk_i))
    else $error("pin b not carrying divider b");
endmodule : osd_top_properties
bind osd_top osd_top_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .status_a_i, .status_b_i, .cmos_b_clk_i,
  .cmos_a_clk_o, .status_pin_a_o, .status_pin_a_oe_n_o, .status_pin_b_o, .status_pin_b_oe_n_o);
`default_nettype wire

// ==== verification/osd_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the divider and status routing block
module osd_top_bench
  import osd_pkg::*;
;
  // One configuration and the periods it should give (0: no clock)
  typedef struct {logic [7:0] c7, rt, ca, src; int e7, ec;} osd_row_s;
  osd_row_s rows [8] = '{'{8'h05, 8'h0A, 8'h00, 8'h00, 6, 0},
    '{8'h01, 8'h14, 8'h01, 8'h00, 2, 24}, '{8'hFF, 8'h24, 8'h05, 8'h00, 256, 30},
    '{8'h03, 8'h14, 8'h06, 8'h04, 4, 56}, '{8'h03, 8'h14, 8'h01, 8'h01, 8, 24},
    '{8'hFF, 8'h3B, 8'h07, 8'h02, 2, 0}, '{8'hFF, 8'hCE, 8'h07, 8'h03, 0, 0},
    '{8'h02, 8'h11, 8'hFF, 8'h00, 3, 1024}};
  logic        clk_i = 1'b0;   // System clock
  logic        rst_i = 1'b1;   // Synchronous reset
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, ch7_clk_o, cmos_a_clk_o;
  logic        status_pin_a_o, status_pin_a_oe_n_o, status_pin_b_o, status_pin_b_oe_n_o;
  logic        synth2_tick_i = 1'b0, ref_pri_i = 1'b0, status_a_i = 1'b0;
  logic        status_b_i = 1'b0, cmos_b_clk_i = 1'b0;
  logic [7:0]  cnt = 8'h00;    // Pattern source for the moving inputs
  logic [7:0]  q_sel;          // Unused result of the masked write
  int          err_total = 0, checked = 0, cycles = 0, n;
  always #2.5 clk_i = ~clk_i;
  osd_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .synth_tick_i(1'b1), .synth2_tick_i, .ref_pri_i,
    .ref_sec_i(1'b1), .status_a_i, .status_b_i, .cmos_b_clk_i, .ch7_clk_o, .cmos_a_clk_o,
    .status_pin_a_o, .status_pin_a_oe_n_o, .status_pin_b_o, .status_pin_b_oe_n_o);
  // Second synthesizer and primary reference tick every other cycle; hang guard
  always @(posedge clk_i) begin
    cnt <= cnt + 8'h01;
    synth2_tick_i <= cnt[0];
    ref_pri_i <= cnt[0];
    status_a_i <= cnt[1];
    status_b_i <= cnt[2];
    cmos_b_clk_i <= cnt[3];
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      results();
    end
  end
  // Classic single bus cycle, held until ack is seen
  task wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
          output logic [7:0] q);
    int i;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= s;
    i = 0;
    do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'b1 && i < 20);
    if (i >= 20) err_total++;
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end
  endtask : chk8
  task chkn(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin err_total++; $display("[ERR] %s exp %0d got %0d", nm, e, g); end
  endtask : chkn
  task wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, 4'h1, q);
  endtask : wr
  task rd(input logic [9:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, 4'hF, q);
    chk8(nm, e, q);
  endtask : rd
  // Cycles between two rising edges of the chosen clock, 0 if none
  task per(input logic s, output int p);
    int i, f;
    logic o, c;
    p = 0;
    f = -1;
    o = 1'b1;
    for (i = 0; i < 2600 && p == 0; i++) begin
      @(posedge clk_i); #1;
      c = s ? cmos_a_clk_o : ch7_clk_o;
      if (c === 1'b1 && o === 1'b0) begin if (f >= 0) p = i - f; else f = i; end
      o = c;
    end
  endtask : per
  task chk_rst;
    rd(OSD_ADDR_CH7_DIV, 8'h05, "ch7_div");
    rd(OSD_ADDR_ROUTE_CTRL, 8'h0A, "route_ctrl");
    rd(OSD_ADDR_CMOS_A, 8'h00, "cmos_a");
  endtask : chk_rst
  task results;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // Table rows, then a refused write, unmapped place and a second reset
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rst();
    foreach (rows[k]) begin
      wr(OSD_ADDR_CH7_DIV, rows[k].c7);
      wr(OSD_ADDR_ROUTE_CTRL, rows[k].rt);
      wr(OSD_ADDR_CMOS_A, rows[k].ca);
      wr(OSD_ADDR_SRC_CTRL, rows[k].src);
      rd(OSD_ADDR_CH7_DIV, rows[k].c7, "ch7_div");
      rd(OSD_ADDR_ROUTE_CTRL, rows[k].rt, "route_ctrl");
      rd(OSD_ADDR_CMOS_A, rows[k].ca, "cmos_a");
      per(1'b0, n);
      per(1'b0, n);
      chkn("ch7_period", rows[k].e7, n);
      per(1'b1, n);
      per(1'b1, n);
      chkn("cmos_a_period", rows[k].ec, n);
    end
    wr(OSD_ADDR_CH7_DIV, 8'h42);
    wb(1'b1, OSD_ADDR_CH7_DIV, 8'h77, 4'hE, q_sel);
    rd(OSD_ADDR_CH7_DIV, 8'h42, "ch7_no_sel");
    wr(10'h3FC, 8'h5A);
    rd(10'h3FC, 8'h00, "unmapped");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rst();
    results();
  end
endmodule : osd_top_bench
`default_nettype wire
